// [design/tmr_top.sv]
// 16-bit timer/counter with capture, compare and shared high-byte latch
`timescale 1ns/10ps
module tmr_top
	import tmr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic capture_input_pin,
	input wire logic external_count_pin,
	output logic waveform_out_a,
	output logic waveform_out_b,
	output logic waveform_en_a,
	output logic waveform_en_b,
	output logic irq_capture,
	output logic irq_compare_a,
	output logic irq_compare_b,
	output logic irq_overflow
);
	// ----------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync_ff;
	logic rst_n;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	logic [2:0] cap_sync_ff, nxt_cap_sync;
	logic [2:0] ext_sync_ff, nxt_ext_sync;
	logic cap_stable_ff, nxt_cap_stable;
	logic ext_stable_ff, nxt_ext_stable;

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [7:0] ctrl_a_ff, nxt_ctrl_a;
	logic [7:0] ctrl_b_ff, nxt_ctrl_b;
	logic [7:0] mask_ff, nxt_mask;
	logic [7:0] flag_ff, nxt_flag;
	logic gie_ff, nxt_gie;
	logic [7:0] temp_ff, nxt_temp;
	logic [15:0] cnt_ff, nxt_cnt;
	logic [15:0] cmpa_ff, nxt_cmpa;
	logic [15:0] cmpb_ff, nxt_cmpb;
	logic [15:0] cap_ff, nxt_cap;
	logic dir_down_ff, nxt_dir_down;
	logic blk_ff, nxt_blk;
	logic [1:0] pend_ff, nxt_pend;
	logic [9:0] pre_ff, nxt_pre;
	logic [2:0] filt_cnt_ff, nxt_filt_cnt;
	logic filt_out_ff, nxt_filt_out;
	logic cap_prev_ff, nxt_cap_prev;
	logic ext_prev_ff, nxt_ext_prev;
	logic wav_a_ff, nxt_wav_a;
	logic wav_b_ff, nxt_wav_b;
	logic [31:0] rdata_ff, nxt_rdata;
	logic ack_ff, nxt_ack;

	logic [3:0] wgm;
	logic [2:0] cs;
	logic [15:0] top;
	logic top_is_cap, pwm_mode, fast_mode, phase_mode, ctc_mode;
	logic tick, cap_src, cap_edge, wr, rd;
	logic [1:0] match;

	assign wgm = {ctrl_b_ff[4:3], ctrl_a_ff[1:0]};
	assign cs = ctrl_b_ff[2:0];
	// a write lands only at the edge after the wait state, when waitrequest is low
	assign wr = avs_write & avs_byteenable[0] & ack_ff;
	assign rd = avs_read & ~ack_ff;

	// one-cycle wait state: answer is registered
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign avs_readdata = rdata_ff;
	assign waveform_out_a = wav_a_ff;
	assign waveform_out_b = wav_b_ff;

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	always_comb begin
		top_is_cap = (wgm == 4'h8) | (wgm == 4'ha) | (wgm == 4'hc) | (wgm == 4'he);
		ctc_mode = (wgm == 4'h4) | (wgm == 4'hc);
		pwm_mode = (wgm != 4'h0) & ~ctc_mode;
		fast_mode = (wgm == 4'h5) | (wgm == 4'h6) | (wgm == 4'h7) | (wgm == 4'he) | (wgm == 4'hf);
		phase_mode = pwm_mode & ~fast_mode;
		unique case (wgm)
			4'h1, 4'h5: top = TMR_TOP_8B;
			4'h2, 4'h6: top = TMR_TOP_9B;
			4'h3, 4'h7: top = TMR_TOP_10B;
			4'h4, 4'h9, 4'hb, 4'hf: top = cmpa_ff;
			4'h8, 4'ha, 4'hc, 4'he: top = cap_ff;
			default: top = TMR_TOP_MAX;
		endcase
	end
	// compare output enables follow the output mode field
	assign waveform_en_a = ctrl_a_ff[7:6] != 2'h0;
	assign waveform_en_b = ctrl_a_ff[5:4] != 2'h0;

	// ----------------------------------------
	// clock select and capture edge
	// ----------------------------------------
	always_comb begin
		unique case (tmr_cs_type'(cs))
			TMR_CS_STOP: tick = 1'b0;
			TMR_CS_DIV1: tick = 1'b1;
			TMR_CS_DIV8: tick = (pre_ff & TMR_DIV8_M) == TMR_DIV8_M;
			TMR_CS_DIV64: tick = (pre_ff & TMR_DIV64_M) == TMR_DIV64_M;
			TMR_CS_DIV256: tick = (pre_ff & TMR_DIV256_M) == TMR_DIV256_M;
			TMR_CS_DIV1024: tick = pre_ff == TMR_DIV1024_M;
			// pin level is read regardless of its port direction
			TMR_CS_EXT_FALL: tick = ext_prev_ff & ~ext_stable_ff;
			TMR_CS_EXT_RISE: tick = ~ext_prev_ff & ext_stable_ff;
		endcase
		cap_src = ctrl_b_ff[TMR_B_FILT_BIT] ? filt_out_ff : cap_stable_ff;
		cap_edge = ctrl_b_ff[TMR_B_EDGE_BIT] ? (cap_src & ~cap_prev_ff) : (~cap_src & cap_prev_ff);
		match[0] = (cnt_ff == cmpa_ff) & ~blk_ff;
		match[1] = (cnt_ff == cmpb_ff) & ~blk_ff;
	end

	// ----------------------------------------
	// next-state
	// ----------------------------------------
	always_comb begin
		logic [7:0] wd;
		logic [1:0] force_s;
		logic at_top;
		logic [7:0] hw_set;
		logic [7:0] clr;
		wd = avs_writedata[7:0];
		force_s = 2'h0;
		at_top = cnt_ff == top;
		hw_set = 8'h00;
		clr = 8'h00;
		nxt_cap_sync = {cap_sync_ff[1:0], capture_input_pin};
		nxt_ext_sync = {ext_sync_ff[1:0], external_count_pin};
		nxt_cap_stable = (cap_sync_ff[2] == cap_sync_ff[1]) ? cap_sync_ff[2] : cap_stable_ff;
		nxt_ext_stable = (ext_sync_ff[2] == ext_sync_ff[1]) ? ext_sync_ff[2] : ext_stable_ff;
		nxt_ctrl_a = ctrl_a_ff;
		nxt_ctrl_b = ctrl_b_ff;
		nxt_mask = mask_ff;
		nxt_flag = flag_ff;
		nxt_gie = gie_ff;
		nxt_temp = temp_ff;
		nxt_cnt = cnt_ff;
		nxt_cmpa = cmpa_ff;
		nxt_cmpb = cmpb_ff;
		nxt_cap = cap_ff;
		nxt_dir_down = dir_down_ff;
		nxt_blk = blk_ff & ~tick;
		nxt_pend = pend_ff;
		nxt_pre = pre_ff + 10'h001;
		nxt_cap_prev = cap_src;
		nxt_ext_prev = ext_stable_ff;
		nxt_wav_a = wav_a_ff;
		nxt_wav_b = wav_b_ff;
		nxt_rdata = 32'h0;
		nxt_ack = (avs_read | avs_write) & ~ack_ff;
		// noise filter: output follows only after four equal samples
		if (cap_stable_ff == filt_out_ff) begin
			nxt_filt_cnt = 3'h0;
			nxt_filt_out = filt_out_ff;
		end else if (filt_cnt_ff == 3'(TMR_FILT_SAMPLES - 1)) begin
			nxt_filt_cnt = 3'h0;
			nxt_filt_out = cap_stable_ff;
		end else begin
			nxt_filt_cnt = filt_cnt_ff + 3'h1;
			nxt_filt_out = filt_out_ff;
		end
		// counter and flags on the timer clock
		if (tick) begin
			hw_set[TMR_F_CMPA_BIT] = pend_ff[0];
			hw_set[TMR_F_CMPB_BIT] = pend_ff[1];
			nxt_pend = match;
			if (!pwm_mode) begin
				if (match[0]) begin
					nxt_wav_a = tmr_apply(ctrl_a_ff[7:6], wav_a_ff);
				end
				if (match[1]) begin
					nxt_wav_b = tmr_apply(ctrl_a_ff[5:4], wav_b_ff);
				end
			end
			if (top_is_cap & at_top) begin
				hw_set[TMR_F_CAP_BIT] = 1'b1;
			end
			if (phase_mode) begin
				if (!dir_down_ff) begin
					nxt_cnt = at_top ? cnt_ff - 16'h1 : cnt_ff + 16'h1;
					nxt_dir_down = at_top;
				end else begin
					nxt_cnt = cnt_ff - 16'h1;
					nxt_dir_down = cnt_ff != 16'h1;
					if (cnt_ff == 16'h0) begin
						hw_set[TMR_F_OVF_BIT] = 1'b1;
						nxt_cnt = 16'h1;
						nxt_dir_down = 1'b0;
					end
				end
			end else begin
				nxt_cnt = (at_top & (fast_mode | ctc_mode)) ? 16'h0 : cnt_ff + 16'h1;
				if (fast_mode ? at_top : (cnt_ff == TMR_TOP_MAX)) begin
					hw_set[TMR_F_OVF_BIT] = 1'b1;
				end
			end
		end
		// capture from the pin, ignored when capture register is top
		if (cap_edge & ~top_is_cap) begin
			nxt_cap = cnt_ff;
			hw_set[TMR_F_CAP_BIT] = 1'b1;
		end
		// register writes
		if (wr) begin
			unique case (avs_address)
				TMR_CTRL_A_OFF: nxt_ctrl_a = wd;
				TMR_CTRL_B_OFF: nxt_ctrl_b = wd & TMR_B_WMASK;
				TMR_CTRL_C_OFF: force_s = pwm_mode ? 2'h0 : {wd[TMR_C_FORCE_B_BIT], wd[TMR_C_FORCE_A_BIT]};
				TMR_CNT_H_OFF, TMR_CMPA_H_OFF, TMR_CMPB_H_OFF, TMR_CAP_H_OFF: nxt_temp = wd;
				TMR_CNT_L_OFF: begin
					nxt_cnt = {temp_ff, wd};
					nxt_blk = 1'b1;
					nxt_pend = 2'h0;
				end
				TMR_CMPA_L_OFF: nxt_cmpa = {temp_ff, wd};
				TMR_CMPB_L_OFF: nxt_cmpb = {temp_ff, wd};
				TMR_CAP_L_OFF: nxt_cap = {temp_ff, wd};
				TMR_MASK_OFF: nxt_mask = wd & TMR_MASK_USED;
				TMR_FLAG_OFF: clr = wd & TMR_MASK_USED;
				TMR_GIE_OFF: nxt_gie = wd[0];
				TMR_VACK_OFF: clr = wd & TMR_MASK_USED;
				default: ;
			endcase
		end
		// a hardware set in the same cycle beats a software clear
		nxt_flag = (flag_ff & ~clr) | hw_set;
		// forced compare: output only, no flag, no counter clear
		if (force_s[0]) begin
			nxt_wav_a = tmr_apply(ctrl_a_ff[7:6], wav_a_ff);
		end
		if (force_s[1]) begin
			nxt_wav_b = tmr_apply(ctrl_a_ff[5:4], wav_b_ff);
		end
		// register reads; low byte read latches the high byte
		if (rd) begin
			unique case (avs_address)
				TMR_CTRL_A_OFF: nxt_rdata[7:0] = ctrl_a_ff;
				TMR_CTRL_B_OFF: nxt_rdata[7:0] = ctrl_b_ff;
				TMR_CTRL_C_OFF: nxt_rdata[7:0] = 8'h00;
				TMR_CNT_L_OFF: begin
					nxt_rdata[7:0] = cnt_ff[7:0];
					nxt_temp = cnt_ff[15:8];
				end
				TMR_CMPA_L_OFF: begin
					nxt_rdata[7:0] = cmpa_ff[7:0];
					nxt_temp = cmpa_ff[15:8];
				end
				TMR_CMPB_L_OFF: begin
					nxt_rdata[7:0] = cmpb_ff[7:0];
					nxt_temp = cmpb_ff[15:8];
				end
				TMR_CAP_L_OFF: begin
					nxt_rdata[7:0] = cap_ff[7:0];
					nxt_temp = cap_ff[15:8];
				end
				TMR_CNT_H_OFF, TMR_CMPA_H_OFF, TMR_CMPB_H_OFF, TMR_CAP_H_OFF: nxt_rdata[7:0] = temp_ff;
				TMR_MASK_OFF: nxt_rdata[7:0] = mask_ff;
				TMR_FLAG_OFF: nxt_rdata[7:0] = flag_ff;
				TMR_GIE_OFF: nxt_rdata[0] = gie_ff;
				default: nxt_rdata = 32'h0;
			endcase
		end
	end

	function automatic logic tmr_apply(input logic [1:0] mode, input logic cur);
		unique case (mode)
			2'h0: tmr_apply = cur;
			2'h1: tmr_apply = ~cur;
			2'h2: tmr_apply = 1'b0;
			2'h3: tmr_apply = 1'b1;
		endcase
	endfunction

	// requests need mask, flag and global enable
	assign irq_capture = gie_ff & mask_ff[TMR_F_CAP_BIT] & flag_ff[TMR_F_CAP_BIT];
	assign irq_compare_b = gie_ff & mask_ff[TMR_F_CMPB_BIT] & flag_ff[TMR_F_CMPB_BIT];
	assign irq_compare_a = gie_ff & mask_ff[TMR_F_CMPA_BIT] & flag_ff[TMR_F_CMPA_BIT];
	assign irq_overflow = gie_ff & mask_ff[TMR_F_OVF_BIT] & flag_ff[TMR_F_OVF_BIT];

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cap_sync_ff <= 3'h0;
			ext_sync_ff <= 3'h0;
			cap_stable_ff <= 1'b0;
			ext_stable_ff <= 1'b0;
			ctrl_a_ff <= TMR_BYTE_RST;
			ctrl_b_ff <= TMR_BYTE_RST;
			mask_ff <= TMR_BYTE_RST;
			flag_ff <= TMR_BYTE_RST;
			gie_ff <= 1'b0;
			temp_ff <= TMR_BYTE_RST;
			cnt_ff <= TMR_WORD_RST;
			cmpa_ff <= TMR_WORD_RST;
			cmpb_ff <= TMR_WORD_RST;
			cap_ff <= TMR_WORD_RST;
			dir_down_ff <= 1'b0;
			blk_ff <= 1'b0;
			pend_ff <= 2'h0;
			pre_ff <= 10'h000;
			filt_cnt_ff <= 3'h0;
			filt_out_ff <= 1'b0;
			cap_prev_ff <= 1'b0;
			ext_prev_ff <= 1'b0;
			wav_a_ff <= 1'b0;
			wav_b_ff <= 1'b0;
			rdata_ff <= 32'h0;
			ack_ff <= 1'b0;
		end else begin
			cap_sync_ff <= nxt_cap_sync;
			ext_sync_ff <= nxt_ext_sync;
			cap_stable_ff <= nxt_cap_stable;
			ext_stable_ff <= nxt_ext_stable;
			ctrl_a_ff <= nxt_ctrl_a;
			ctrl_b_ff <= nxt_ctrl_b;
			mask_ff <= nxt_mask;
			flag_ff <= nxt_flag;
			gie_ff <= nxt_gie;
			temp_ff <= nxt_temp;
			cnt_ff <= nxt_cnt;
			cmpa_ff <= nxt_cmpa;
			cmpb_ff <= nxt_cmpb;
			cap_ff <= nxt_cap;
			dir_down_ff <= nxt_dir_down;
			blk_ff <= nxt_blk;
			pend_ff <= nxt_pend;
			pre_ff <= nxt_pre;
			filt_cnt_ff <= nxt_filt_cnt;
			filt_out_ff <= nxt_filt_out;
			cap_prev_ff <= nxt_cap_prev;
			ext_prev_ff <= nxt_ext_prev;
			wav_a_ff <= nxt_wav_a;
			wav_b_ff <= nxt_wav_b;
			rdata_ff <= nxt_rdata;
			ack_ff <= nxt_ack;
		end
	end
endmodule // tmr_top

// [design/tmr_pkg.sv]
// package for the 16-bit capture/compare timer register block
package tmr_pkg;
	// ----------------------------------------
	// register byte offsets (8-bit registers, one per aligned word)
	// ----------------------------------------
	localparam logic [5:0] TMR_CTRL_A_OFF = 6'h00;
	localparam logic [5:0] TMR_CTRL_B_OFF = 6'h04;
	localparam logic [5:0] TMR_CTRL_C_OFF = 6'h08;
	localparam logic [5:0] TMR_CNT_L_OFF = 6'h0c;
	localparam logic [5:0] TMR_CNT_H_OFF = 6'h10;
	localparam logic [5:0] TMR_CMPA_L_OFF = 6'h14;
	localparam logic [5:0] TMR_CMPA_H_OFF = 6'h18;
	localparam logic [5:0] TMR_CMPB_L_OFF = 6'h1c;
	localparam logic [5:0] TMR_CMPB_H_OFF = 6'h20;
	localparam logic [5:0] TMR_CAP_L_OFF = 6'h24;
	localparam logic [5:0] TMR_CAP_H_OFF = 6'h28;
	localparam logic [5:0] TMR_MASK_OFF = 6'h2c;
	localparam logic [5:0] TMR_FLAG_OFF = 6'h30;
	localparam logic [5:0] TMR_GIE_OFF = 6'h34;
	localparam logic [5:0] TMR_VACK_OFF = 6'h38;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int TMR_B_FILT_BIT = 7;
	localparam int TMR_B_EDGE_BIT = 6;
	localparam int TMR_B_RSVD_BIT = 5;
	localparam int TMR_C_FORCE_A_BIT = 7;
	localparam int TMR_C_FORCE_B_BIT = 6;
	localparam int TMR_F_CAP_BIT = 5;
	localparam int TMR_F_CMPB_BIT = 2;
	localparam int TMR_F_CMPA_BIT = 1;
	localparam int TMR_F_OVF_BIT = 0;
	localparam logic [7:0] TMR_MASK_USED = 8'h27;
	localparam logic [7:0] TMR_B_WMASK = 8'hdf;
	// ----------------------------------------
	// reset values and fixed tops
	// ----------------------------------------
	localparam logic [7:0] TMR_BYTE_RST = 8'h00;
	localparam logic [15:0] TMR_WORD_RST = 16'h0000;
	localparam logic [15:0] TMR_TOP_MAX = 16'hffff;
	localparam logic [15:0] TMR_TOP_8B = 16'h00ff;
	localparam logic [15:0] TMR_TOP_9B = 16'h01ff;
	localparam logic [15:0] TMR_TOP_10B = 16'h03ff;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int TMR_FILT_SAMPLES = 4;
	localparam int TMR_PRE_WIDTH = 10;
	localparam logic [9:0] TMR_DIV8_M = 10'h007;
	localparam logic [9:0] TMR_DIV64_M = 10'h03f;
	localparam logic [9:0] TMR_DIV256_M = 10'h0ff;
	localparam logic [9:0] TMR_DIV1024_M = 10'h3ff;
	// ----------------------------------------
	// clock select codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		TMR_CS_STOP = 3'h0, TMR_CS_DIV1 = 3'h1, TMR_CS_DIV8 = 3'h2, TMR_CS_DIV64 = 3'h3,
		TMR_CS_DIV256 = 3'h4, TMR_CS_DIV1024 = 3'h5, TMR_CS_EXT_FALL = 3'h6, TMR_CS_EXT_RISE = 3'h7
	} tmr_cs_type;
endpackage

// [bench/tmr_top_assertions.sv]
// port-level checker for the timer register block
`timescale 1ns/10ps
module tmr_top_assertions
	import tmr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic capture_input_pin,
	input wire logic external_count_pin,
	input wire logic waveform_out_a,
	input wire logic waveform_out_b,
	input wire logic waveform_en_a,
	input wire logic waveform_en_b,
	input wire logic irq_capture,
	input wire logic irq_compare_a,
	input wire logic irq_compare_b,
	input wire logic irq_overflow
);
	// ----
	// helpers
	// ----
	logic req;
	logic wdone;
	logic irq_any;
	assign req = avs_read | avs_write;
	assign wdone = avs_write & !avs_waitrequest & avs_byteenable[0];
	assign irq_any = irq_capture | irq_compare_a | irq_compare_b | irq_overflow;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// ----
	// properties
	// ----
	a_wait_first: assert property ($rose(req) |-> avs_waitrequest) else $error("no wait cycle");
	a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("wait too long");
	a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_force_zero: assert property (avs_read && !avs_waitrequest && avs_address == TMR_CTRL_C_OFF
		|-> avs_readdata[7:0] == 8'h00) else $error("force bits read nonzero");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > TMR_VACK_OFF
		|-> avs_readdata == 32'h00000000) else $error("unmapped read nonzero");
	a_mode_enable: assert property (wdone && avs_address == TMR_CTRL_A_OFF |=>
		waveform_en_a == ($past(avs_writedata[7:6]) != 2'h0) && waveform_en_b == ($past(avs_writedata[5:4]) != 2'h0))
		else $error("output enable mismatch");
	a_bytes_ignored: assert property (avs_write && !avs_waitrequest && !avs_byteenable[0]
		|=> $stable(waveform_en_a) && $stable(waveform_en_b)) else $error("masked write acted");
	a_gie_off: assert property (wdone && avs_address == TMR_GIE_OFF && !avs_writedata[0]
		|=> !irq_any) else $error("irq without global enable");
	a_mask_off: assert property (wdone && avs_address == TMR_MASK_OFF && avs_writedata[7:0] == 8'h00
		|=> !irq_any) else $error("irq without mask");
endmodule // tmr_top_assertions

// [bench/tmr_top_bench.sv]
// self-checking bench for the timer register block
`timescale 1ns/10ps
module tmr_top_bench
	import tmr_pkg::*;
;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h1;
	logic capture_input_pin = 1'b0;
	logic external_count_pin = 1'b0;
	logic [3:0] be = 4'h1;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, waveform_out_a, waveform_out_b, waveform_en_a, waveform_en_b;
	logic irq_capture, irq_compare_a, irq_compare_b, irq_overflow;
	logic [15:0] v;
	logic [7:0] q;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	int n0, n1;
	always #2.5 clk_sys = ~clk_sys;
	tmr_top DUT (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .capture_input_pin(capture_input_pin),
		.external_count_pin(external_count_pin), .waveform_out_a(waveform_out_a), .waveform_out_b(waveform_out_b),
		.waveform_en_a(waveform_en_a), .waveform_en_b(waveform_en_b), .irq_capture(irq_capture),
		.irq_compare_a(irq_compare_a), .irq_compare_b(irq_compare_b), .irq_overflow(irq_overflow));
	// ----
	// report and bus tasks
	// ----
	task automatic conclude();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 80000) begin
			errors++;
			conclude();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// prescaler phase and bus latency make counts approximate
	task automatic near(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if ($isunknown(g) || g > e + 16'h0004 || g + 16'h0004 < e) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			@(posedge clk_sys);
			n++;
		end
		if (n == 50) errors++;
		r = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] r;
		bus(a, 1'b1, d, r);
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] r);
		bus(a, 1'b0, 8'h00, r);
	endtask
	// high byte goes first so the shared latch holds it at the low write
	task automatic w16(input logic [5:0] a, input logic [15:0] d);
		wr(a + 6'h04, d[15:8]);
		wr(a, d[7:0]);
	endtask
	task automatic r16(input logic [5:0] a, output logic [15:0] d);
		rd(a, d[7:0]);
		rd(a + 6'h04, d[15:8]);
	endtask
	task automatic run(input logic [7:0] b, input int n);
		wr(TMR_CTRL_B_OFF, b);
		repeat (n) @(posedge clk_sys);
		wr(TMR_CTRL_B_OFF, b & 8'hf8);
	endtask
	// ----
	// scenarios
	// ----
	task automatic s_regs();
		rd(TMR_MASK_OFF, q);
		chk(16'(q), 16'(TMR_BYTE_RST));
		wr(TMR_MASK_OFF, 8'hff);
		rd(TMR_MASK_OFF, q);
		chk(16'(q), 16'(TMR_MASK_USED));
		wr(TMR_MASK_OFF, 8'h00);
		wr(TMR_CTRL_C_OFF, 8'hc0);
		rd(TMR_CTRL_C_OFF, q);
		chk(16'(q), 16'h0000);
		rd(6'h3c, q);
		chk(16'(q), 16'h0000);
		be = 4'h0;
		wr(TMR_CTRL_A_OFF, 8'hf0);
		be = 4'h1;
		chk(16'(waveform_en_a), 16'h0000);
	endtask
	task automatic s_latch();
		w16(TMR_CMPA_L_OFF, 16'h1234);
		w16(TMR_CMPB_L_OFF, 16'habcd);
		r16(TMR_CMPA_L_OFF, v);
		chk(v, 16'h1234);
		r16(TMR_CMPB_L_OFF, v);
		chk(v, 16'habcd);
		wr(TMR_CMPA_H_OFF, 8'h77);
		wr(TMR_CNT_L_OFF, 8'h00);
		r16(TMR_CNT_L_OFF, v);
		chk(v, 16'h7700);
	endtask
	task automatic s_count();
		logic [15:0] e [8] = '{16'h0000, 16'h1000, 16'h0200, 16'h0040, 16'h0010, 16'h0004, 16'h000a, 16'h000a};
		for (int c = 0; c < 8; c++) begin
			w16(TMR_CNT_L_OFF, 16'h0000);
			wr(TMR_CTRL_B_OFF, 8'(c));
			if (c < 6) begin
				repeat (4096) @(posedge clk_sys);
			end else begin
				repeat (10) begin
					repeat (4) @(posedge clk_sys);
					external_count_pin <= 1'b1;
					repeat (4) @(posedge clk_sys);
					external_count_pin <= 1'b0;
				end
				repeat (10) @(posedge clk_sys);
			end
			wr(TMR_CTRL_B_OFF, 8'h00);
			r16(TMR_CNT_L_OFF, v);
			near(v, e[c]);
		end
	endtask
	task automatic s_match();
		w16(TMR_CMPA_L_OFF, 16'h0040);
		wr(TMR_CTRL_A_OFF, 8'h40);
		wr(TMR_MASK_OFF, 8'h27);
		wr(TMR_GIE_OFF, 8'h01);
		w16(TMR_CNT_L_OFF, 16'h0000);
		run(8'h01, 100);
		chk(16'(irq_compare_a), 16'h0001);
		chk(16'(waveform_out_a), 16'h0001);
		chk(16'(irq_compare_b), 16'h0000);
		wr(TMR_FLAG_OFF, 8'h02);
		chk(16'(irq_compare_a), 16'h0000);
		w16(TMR_CNT_L_OFF, 16'hfff0);
		run(8'h01, 40);
		wr(TMR_MASK_OFF, 8'h26);
		chk(16'(irq_overflow), 16'h0000);
		wr(TMR_MASK_OFF, 8'h27);
		chk(16'(irq_overflow), 16'h0001);
		wr(TMR_VACK_OFF, 8'h01);
		chk(16'(irq_overflow), 16'h0000);
		w16(TMR_CMPB_L_OFF, 16'h0100);
		w16(TMR_CNT_L_OFF, 16'h0100);
		run(8'h01, 20);
		chk(16'(irq_compare_b), 16'h0000);
		w16(TMR_CNT_L_OFF, 16'h00ff);
		run(8'h01, 20);
		chk(16'(irq_compare_b), 16'h0001);
		wr(TMR_FLAG_OFF, 8'hff);
	endtask
	task automatic s_force();
		logic a;
		wr(TMR_CTRL_A_OFF, 8'h70);
		a = waveform_out_a;
		wr(TMR_CTRL_C_OFF, 8'hc0);
		@(posedge clk_sys);
		chk(16'(waveform_out_a), 16'(!a));
		chk(16'(waveform_out_b), 16'h0001);
		chk(16'(irq_compare_a), 16'h0000);
		chk(16'(irq_compare_b), 16'h0000);
		wr(TMR_CTRL_A_OFF, 8'h71);
		a = waveform_out_a;
		wr(TMR_CTRL_C_OFF, 8'h80);
		@(posedge clk_sys);
		chk(16'(waveform_out_a), 16'(a));
		wr(TMR_CTRL_A_OFF, 8'h00);
	endtask
	task automatic s_capture();
		w16(TMR_CNT_L_OFF, 16'h1234);
		wr(TMR_CTRL_B_OFF, 8'h40);
		capture_input_pin <= 1'b1;
		repeat (20) @(posedge clk_sys);
		r16(TMR_CAP_L_OFF, v);
		chk(v, 16'h1234);
		chk(16'(irq_capture), 16'h0001);
		wr(TMR_FLAG_OFF, 8'hff);
		wr(TMR_CTRL_B_OFF, 8'h00);
		w16(TMR_CNT_L_OFF, 16'h0055);
		capture_input_pin <= 1'b0;
		repeat (20) @(posedge clk_sys);
		r16(TMR_CAP_L_OFF, v);
		chk(v, 16'h0055);
		wr(TMR_FLAG_OFF, 8'hff);
		capture_input_pin <= 1'b1;
		repeat (20) @(posedge clk_sys);
		chk(16'(irq_capture), 16'h0000);
		w16(TMR_CNT_L_OFF, 16'h0000);
		wr(TMR_CTRL_B_OFF, 8'h58);
		capture_input_pin <= 1'b0;
		repeat (20) @(posedge clk_sys);
		capture_input_pin <= 1'b1;
		repeat (20) @(posedge clk_sys);
		chk(16'(irq_capture), 16'h0000);
		run(8'h59, 200);
		chk(16'(irq_capture), 16'h0001);
		wr(TMR_CTRL_B_OFF, 8'h00);
	endtask
	task automatic lat(input logic [7:0] b, output int n);
		wr(TMR_CTRL_B_OFF, b);
		capture_input_pin <= 1'b0;
		repeat (20) @(posedge clk_sys);
		wr(TMR_FLAG_OFF, 8'hff);
		capture_input_pin <= 1'b1;
		n = 0;
		while (irq_capture !== 1'b1 && n < 60) begin
			@(posedge clk_sys);
			n++;
		end
	endtask
	task automatic s_filter();
		lat(8'h40, n0);
		lat(8'hc0, n1);
		chk(16'(n1 - n0), 16'h0004);
		capture_input_pin <= 1'b0;
		repeat (20) @(posedge clk_sys);
		wr(TMR_FLAG_OFF, 8'hff);
		capture_input_pin <= 1'b1;
		repeat (2) @(posedge clk_sys);
		capture_input_pin <= 1'b0;
		repeat (20) @(posedge clk_sys);
		chk(16'(irq_capture), 16'h0000);
		wr(TMR_GIE_OFF, 8'h00);
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		s_regs();
		s_latch();
		s_count();
		s_match();
		s_force();
		s_capture();
		s_filter();
		conclude();
	end
endmodule // tmr_top_bench
bind tmr_top tmr_top_assertions chk_i (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .capture_input_pin(capture_input_pin),
	.external_count_pin(external_count_pin), .waveform_out_a(waveform_out_a), .waveform_out_b(waveform_out_b),
	.waveform_en_a(waveform_en_a), .waveform_en_b(waveform_en_b), .irq_capture(irq_capture),
	.irq_compare_a(irq_compare_a), .irq_compare_b(irq_compare_b), .irq_overflow(irq_overflow));
